/* verilog/fpll_defines.svh */
// register offsets, field positions, reset values and counts of the pll
// controller; included by its bare name, definitions only
`ifndef FPLL_DEFINES_SVH
`define FPLL_DEFINES_SVH

`define FPLL_OFF_CTRLA       8'h00
`define FPLL_OFF_CTRLB       8'h04
`define FPLL_OFF_RATIO       8'h08
`define FPLL_OFF_STATUS      8'h0C
`define FPLL_OFF_INTERRUPT_FLAG_REGISTER     8'h10
`define FPLL_OFF_INTERRUPT_ENABLE_SET    8'h14
`define FPLL_OFF_INTENCLR    8'h18

`define FPLL_CTRLA_ENABLE    1
`define FPLL_CTRLB_FILTER    0
`define FPLL_CTRLB_CONVBYP   2
`define FPLL_CTRLB_WUF       3
`define FPLL_CTRLB_REFSEL    4
`define FPLL_CTRLB_LOCK_TIME_SELECT     8
`define FPLL_CTRLB_LOCK_BYPASS   12
`define FPLL_CTRLB_DIV       16
`define FPLL_RATIO_INT       0
`define FPLL_RATIO_FRAC      16
`define FPLL_STATUS_LOCK     0
`define FPLL_STATUS_CLKRDY   1
`define FPLL_STATUS_ENABLE   2
`define FPLL_STATUS_FRAC     3
`define FPLL_FLAG_LOCK       0
`define FPLL_FLAG_LOCK_LOST_FLAG      1
`define FPLL_FLAG_LOCK_TIMEOUT_FLAG       2

`define FPLL_CTRLA_RST       32'h00000000
`define FPLL_CTRLB_RST       32'h00000000
`define FPLL_RATIO_RST       32'h00000000

`define FPLL_REF_CRYSTAL_32K_OSCILLATOR     2'h0
`define FPLL_REF_XOSC        2'h1
`define FPLL_REF_GCLK        2'h2

`define FPLL_FILTER_AUTO_INT  2'h1
`define FPLL_FILTER_AUTO_FRAC 2'h2

`define FPLL_SETTLE_REF_EDGES 4'h4
`define FPLL_LOCK_TIME_SELECT_STEP_TICKS 11'h020

`define FPLL_RESP_OKAY       2'h0
`define FPLL_RESP_SLVERR     2'h2

`endif

/* verilog/fpll_pkg.sv */
// types shared by the pll controller files
// widths follow the register layout in fpll_defines.svh
package fpll_pkg;

  typedef struct packed {
    logic [10:0] div;
    logic        lock_bypass;
    logic [2:0]  lock_time_select;
    logic [1:0]  reference_select;
    logic        wake_up_fast;
    logic        converter_bypass_enable;
    logic [1:0]  filter;
  } fpll_ctrlb_t;

  typedef struct packed {
    logic [11:0] loop_ratio_integer;
    logic [3:0]  loop_ratio_fraction;
  } fpll_ratio_t;

  typedef struct packed {
    logic [16:0] ratio_sixteenths;
    logic        fraction_mode;
    logic [1:0]  filter;
    logic        converter_bypass;
    logic        osc_reset;
  } fpll_dco_ctl_t;

  typedef enum logic [1:0] {
    FPLL_ST_OFF,
    FPLL_ST_ACQUIRE,
    FPLL_ST_FAST,
    FPLL_ST_RUN
  } fpll_state_t;

endpackage

/* verilog/fpll_ref_sel.sv */
// reference selection and crystal divider of the pll controller
// source clocks are slow levels sampled on clk_sys
`timescale 1ns/1ps
`include "fpll_defines.svh"
module fpll_ref_sel (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [1:0]  reference_select,
  input  wire logic [10:0] div,
  input  wire logic        crystal_32k_oscillator,
  input  wire logic        main_crystal_oscillator,
  input  wire logic        generic_reference_clock,
  output logic             pll_reference_clock,
  output logic             ref_edge
);
  logic        xosc_d_ff;
  logic        nxt_xosc_d;
  logic [10:0] div_cnt_ff;
  logic [10:0] nxt_div_cnt;
  logic        div_clk_ff;
  logic        nxt_div_clk;
  logic        ref_ff;
  logic        nxt_ref;
  logic        ref_d_ff;
  logic        nxt_ref_d;

  always_comb begin
    nxt_xosc_d  = main_crystal_oscillator;
    nxt_div_cnt = div_cnt_ff;
    nxt_div_clk = div_clk_ff;
    if (main_crystal_oscillator && !xosc_d_ff) begin
      if (div_cnt_ff >= div) begin
        nxt_div_cnt = 11'h000;
        nxt_div_clk = !div_clk_ff;
      end else begin
        nxt_div_cnt = div_cnt_ff + 11'h001;
      end
    end
    unique case (reference_select)
      `FPLL_REF_CRYSTAL_32K_OSCILLATOR: nxt_ref = crystal_32k_oscillator;
      `FPLL_REF_XOSC:    nxt_ref = div_clk_ff;
      `FPLL_REF_GCLK:    nxt_ref = generic_reference_clock;
      default:           nxt_ref = 1'b0;
    endcase
    nxt_ref_d = ref_ff;
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      xosc_d_ff  <= 1'b0;
      div_cnt_ff <= 11'h000;
      div_clk_ff <= 1'b0;
      ref_ff     <= 1'b0;
      ref_d_ff   <= 1'b0;
    end else begin
      xosc_d_ff  <= nxt_xosc_d;
      div_cnt_ff <= nxt_div_cnt;
      div_clk_ff <= nxt_div_clk;
      ref_ff     <= nxt_ref;
      ref_d_ff   <= nxt_ref_d;
    end
  end

  assign pll_reference_clock = ref_ff;
  assign ref_edge            = ref_ff && !ref_d_ff;
endmodule

/* verilog/fpll_lock_timer.sv */
// lock timer of the pll controller, counting lock_timer_clock rises
// lock_timer_clock is a slow level sampled on clk_sys
`timescale 1ns/1ps
`include "fpll_defines.svh"
module fpll_lock_timer (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       start,
  input  wire logic       run,
  input  wire logic [2:0] lock_time_select,
  input  wire logic       lock_timer_clock,
  output logic            timer_done,
  output logic            timeout_pulse
);
  logic        tick_d_ff;
  logic        nxt_tick_d;
  logic [10:0] cnt_ff;
  logic [10:0] nxt_cnt;
  logic        done_ff;
  logic        nxt_done;
  logic        pulse_ff;
  logic        nxt_pulse;
  logic        tick;
  logic [13:0] load;

  assign tick = lock_timer_clock && !tick_d_ff;
  assign load = {11'h000, lock_time_select} * {3'h0, `FPLL_LOCK_TIME_SELECT_STEP_TICKS};

  always_comb begin
    nxt_tick_d = lock_timer_clock;
    nxt_cnt    = cnt_ff;
    nxt_done   = done_ff;
    nxt_pulse  = 1'b0;
    if (!run) begin
      nxt_cnt  = 11'h000;
      nxt_done = 1'b0;
    end else if (start) begin
      nxt_cnt  = load[10:0];
      nxt_done = 1'b0;
    end else if (!done_ff && tick) begin
      if (cnt_ff <= 11'h001) begin
        nxt_cnt   = 11'h000;
        nxt_done  = 1'b1;
        nxt_pulse = 1'b1;
      end else begin
        nxt_cnt = cnt_ff - 11'h001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tick_d_ff <= 1'b0;
      cnt_ff    <= 11'h000;
      done_ff   <= 1'b0;
      pulse_ff  <= 1'b0;
    end else begin
      tick_d_ff <= nxt_tick_d;
      cnt_ff    <= nxt_cnt;
      done_ff   <= nxt_done;
      pulse_ff  <= nxt_pulse;
    end
  end

  assign timer_done    = done_ff;
  assign timeout_pulse = pulse_ff;
endmodule

/* verilog/fpll_ctrl.sv */
// fractional pll controller: axi4-lite registers, lock handling, gate
// assumes sources and oscillator signals are synchronous to clk_sys
//
// What this block does
// - output equals reference times ratio plus one plus sixteenths
// - crystal path divides by two times divider-plus-one
// - reference from 32k crystal, crystal, generic clock
// - zero fraction means integer mode, else fractional
// - enable starts loop; disabled holds oscillator reset
// - frequency stable only while enabled and locked
// - nonzero lock time validates lock by timer
// - wake-up-fast opens gate at start-up end
// - otherwise first edge at lock or timer zero
// - after first edge, no bypass: gate follows lock; with wake-up-fast, only from first lock
// - after first edge, bypass keeps output running
// - output depends only on internal final gate
// - ratio write while enabled clears lock until settled
// - lock fall sets lock-fail flag; write one clears
// - automatic filter unless nonzero override written
// - low-power field bypasses the time-to-digital converter
// - timeout flag set when lock time elapses
// - lock flag set when lock status rises
// - interrupt while flag set and enabled
`timescale 1ns/1ps
`include "fpll_defines.svh"
module fpll_ctrl (
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   crystal_32k_oscillator,
  input  wire logic                   main_crystal_oscillator,
  input  wire logic                   generic_reference_clock,
  input  wire logic                   lock_timer_clock,
  input  wire logic                   oscillator_raw_clock,
  input  wire logic                   osc_startup_done,
  input  wire logic                   pll_core_lock,
  output logic                        pll_reference_clock,
  output logic                        pll_output_clock,
  output logic                        final_clock_gate,
  output fpll_pkg::fpll_dco_ctl_t     dco_ctl,
  output logic                        irq
);
  logic                  ctrla_en_ff;
  logic                  nxt_ctrla_en;
  logic                  en_d_ff;
  fpll_pkg::fpll_ctrlb_t ctrlb_ff;
  fpll_pkg::fpll_ctrlb_t nxt_ctrlb;
  fpll_pkg::fpll_ratio_t ratio_ff;
  fpll_pkg::fpll_ratio_t nxt_ratio;
  logic [2:0]            flag_ff;
  logic [2:0]            nxt_flag;
  logic [2:0]            inten_ff;
  logic [2:0]            nxt_inten;
  logic                  bvalid_ff;
  logic                  nxt_bvalid;
  logic [1:0]            bresp_ff;
  logic [1:0]            nxt_bresp;
  logic                  rvalid_ff;
  logic                  nxt_rvalid;
  logic [31:0]           rdata_ff;
  logic [31:0]           nxt_rdata;
  logic [1:0]            rresp_ff;
  logic [1:0]            nxt_rresp;
  fpll_pkg::fpll_state_t state_ff;
  fpll_pkg::fpll_state_t nxt_state;
  logic                  lock_ff;
  logic                  nxt_lock;
  logic [3:0]            settle_ff;
  logic [3:0]            nxt_settle;
  logic                  gate_ff;
  logic                  nxt_gate;
  logic                  wr_go;
  logic                  rd_go;
  logic [31:0]           wmask;
  logic [31:0]           wword;
  logic                  start;
  logic                  ref_edge;
  logic                  timer_done;
  logic                  timeout_pulse;
  logic                  open_cond;

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == `FPLL_OFF_CTRLA)   || (a == `FPLL_OFF_CTRLB) ||
              (a == `FPLL_OFF_RATIO)   || (a == `FPLL_OFF_STATUS) ||
              (a == `FPLL_OFF_INTERRUPT_FLAG_REGISTER) || (a == `FPLL_OFF_INTERRUPT_ENABLE_SET) ||
              (a == `FPLL_OFF_INTENCLR);
  endfunction

  function automatic logic [31:0] reg_read(input logic [7:0] a,
      input logic en, input fpll_pkg::fpll_ctrlb_t b,
      input fpll_pkg::fpll_ratio_t r, input logic [2:0] f,
      input logic [2:0] ie, input logic lk, input logic g);
    reg_read = 32'h00000000;
    unique case (a)
      `FPLL_OFF_CTRLA: reg_read[`FPLL_CTRLA_ENABLE] = en;
      `FPLL_OFF_CTRLB: begin
        reg_read[`FPLL_CTRLB_FILTER +: 2]  = b.filter;
        reg_read[`FPLL_CTRLB_CONVBYP]      = b.converter_bypass_enable;
        reg_read[`FPLL_CTRLB_WUF]          = b.wake_up_fast;
        reg_read[`FPLL_CTRLB_REFSEL +: 2]  = b.reference_select;
        reg_read[`FPLL_CTRLB_LOCK_TIME_SELECT +: 3]   = b.lock_time_select;
        reg_read[`FPLL_CTRLB_LOCK_BYPASS]      = b.lock_bypass;
        reg_read[`FPLL_CTRLB_DIV +: 11]    = b.div;
      end
      `FPLL_OFF_RATIO: begin
        reg_read[`FPLL_RATIO_INT +: 12] = r.loop_ratio_integer;
        reg_read[`FPLL_RATIO_FRAC +: 4] = r.loop_ratio_fraction;
      end
      `FPLL_OFF_STATUS: begin
        reg_read[`FPLL_STATUS_LOCK]   = lk;
        reg_read[`FPLL_STATUS_CLKRDY] = g;
        reg_read[`FPLL_STATUS_ENABLE] = en;
        reg_read[`FPLL_STATUS_FRAC]   = (r.loop_ratio_fraction != 4'h0);
      end
      `FPLL_OFF_INTERRUPT_FLAG_REGISTER:  reg_read[2:0] = f;
      `FPLL_OFF_INTERRUPT_ENABLE_SET: reg_read[2:0] = ie;
      `FPLL_OFF_INTENCLR: reg_read[2:0] = ie;
      default:            reg_read = 32'h00000000;
    endcase
  endfunction

  fpll_ref_sel u_ref (
    .clk_sys                 (clk_sys),
    .rstn                    (rstn),
    .reference_select        (ctrlb_ff.reference_select),
    .div                     (ctrlb_ff.div),
    .crystal_32k_oscillator  (crystal_32k_oscillator),
    .main_crystal_oscillator (main_crystal_oscillator),
    .generic_reference_clock (generic_reference_clock),
    .pll_reference_clock     (pll_reference_clock),
    .ref_edge                (ref_edge)
  );

  assign start = ctrla_en_ff && !en_d_ff;

  fpll_lock_timer u_timer (
    .clk_sys          (clk_sys),
    .rstn             (rstn),
    .start            (start),
    .run              (ctrla_en_ff),
    .lock_time_select (ctrlb_ff.lock_time_select),
    .lock_timer_clock (lock_timer_clock),
    .timer_done       (timer_done),
    .timeout_pulse    (timeout_pulse)
  );

  // bus handshake
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
  assign rd_go = s_axi_arvalid && !rvalid_ff;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  generate
    for (genvar i = 0; i < 4; i++) begin : g_mask
      assign wmask[8*i +: 8] = {8{s_axi_wstrb[i]}};
    end
  endgenerate

  assign wword = (reg_read(s_axi_awaddr, ctrla_en_ff, ctrlb_ff, ratio_ff,
                           flag_ff, inten_ff, lock_ff, gate_ff) & ~wmask)
               | (s_axi_wdata & wmask);

  // register writes and reads
  always_comb begin
    nxt_ctrla_en = ctrla_en_ff;
    nxt_ctrlb    = ctrlb_ff;
    nxt_ratio    = ratio_ff;
    nxt_inten    = inten_ff;
    nxt_bvalid   = bvalid_ff && !s_axi_bready;
    nxt_bresp    = bresp_ff;
    nxt_rvalid   = rvalid_ff && !s_axi_rready;
    nxt_rdata    = rdata_ff;
    nxt_rresp    = rresp_ff;
    if (wr_go) begin
      nxt_bvalid = 1'b1;
      nxt_bresp  = reg_hit(s_axi_awaddr) ? `FPLL_RESP_OKAY
                                         : `FPLL_RESP_SLVERR;
      unique case (s_axi_awaddr)
        `FPLL_OFF_CTRLA: nxt_ctrla_en = wword[`FPLL_CTRLA_ENABLE];
        `FPLL_OFF_CTRLB: begin
          nxt_ctrlb.filter                  = wword[`FPLL_CTRLB_FILTER +: 2];
          nxt_ctrlb.converter_bypass_enable = wword[`FPLL_CTRLB_CONVBYP];
          nxt_ctrlb.wake_up_fast            = wword[`FPLL_CTRLB_WUF];
          nxt_ctrlb.reference_select        = wword[`FPLL_CTRLB_REFSEL +: 2];
          nxt_ctrlb.lock_time_select        = wword[`FPLL_CTRLB_LOCK_TIME_SELECT +: 3];
          nxt_ctrlb.lock_bypass             = wword[`FPLL_CTRLB_LOCK_BYPASS];
          nxt_ctrlb.div                     = wword[`FPLL_CTRLB_DIV +: 11];
        end
        `FPLL_OFF_RATIO: begin
          nxt_ratio.loop_ratio_integer  = wword[`FPLL_RATIO_INT +: 12];
          nxt_ratio.loop_ratio_fraction = wword[`FPLL_RATIO_FRAC +: 4];
        end
        `FPLL_OFF_INTERRUPT_ENABLE_SET: nxt_inten = inten_ff | s_axi_wdata[2:0];
        `FPLL_OFF_INTENCLR: nxt_inten = inten_ff & ~s_axi_wdata[2:0];
        default: nxt_ctrla_en = ctrla_en_ff;
      endcase
    end
    if (rd_go) begin
      nxt_rvalid = 1'b1;
      nxt_rdata  = reg_read(s_axi_araddr, ctrla_en_ff, ctrlb_ff, ratio_ff,
                            flag_ff, inten_ff, lock_ff, gate_ff);
      nxt_rresp  = reg_hit(s_axi_araddr) ? `FPLL_RESP_OKAY
                                         : `FPLL_RESP_SLVERR;
    end
  end

  // lock status, settling and flags
  always_comb begin
    nxt_settle = settle_ff;
    if (!ctrla_en_ff) begin
      nxt_settle = 4'h0;
    end else if (wr_go && s_axi_awaddr == `FPLL_OFF_RATIO) begin
      nxt_settle = `FPLL_SETTLE_REF_EDGES;
    end else if (settle_ff != 4'h0 && ref_edge && pll_core_lock) begin
      nxt_settle = settle_ff - 4'h1;
    end
    if (ctrlb_ff.lock_time_select != 3'h0) begin
      nxt_lock = timer_done;
    end else begin
      nxt_lock = pll_core_lock;
    end
    nxt_lock = nxt_lock && ctrla_en_ff && (nxt_settle == 4'h0);
    nxt_flag = flag_ff;
    if (wr_go && s_axi_awaddr == `FPLL_OFF_INTERRUPT_FLAG_REGISTER) begin
      nxt_flag = flag_ff & ~(s_axi_wdata[2:0] & {3{s_axi_wstrb[0]}});
    end
    if (nxt_lock && !lock_ff) begin
      nxt_flag[`FPLL_FLAG_LOCK] = 1'b1;
    end
    if (!nxt_lock && lock_ff) begin
      nxt_flag[`FPLL_FLAG_LOCK_LOST_FLAG] = 1'b1;
    end
    if (timeout_pulse) begin
      nxt_flag[`FPLL_FLAG_LOCK_TIMEOUT_FLAG] = 1'b1;
    end
  end

  // start-up sequence and final gate
  always_comb begin
    if (ctrlb_ff.wake_up_fast) begin
      open_cond = osc_startup_done;
    end else if (ctrlb_ff.lock_time_select == 3'h0) begin
      open_cond = lock_ff;
    end else begin
      open_cond = timer_done;
    end
    nxt_state = state_ff;
    unique case (state_ff)
      fpll_pkg::FPLL_ST_OFF: begin
        if (ctrla_en_ff) nxt_state = fpll_pkg::FPLL_ST_ACQUIRE;
      end
      fpll_pkg::FPLL_ST_ACQUIRE: begin
        if (!ctrla_en_ff) nxt_state = fpll_pkg::FPLL_ST_OFF;
        else if (open_cond && ctrlb_ff.wake_up_fast)
          nxt_state = fpll_pkg::FPLL_ST_FAST;
        else if (open_cond) nxt_state = fpll_pkg::FPLL_ST_RUN;
      end
      fpll_pkg::FPLL_ST_FAST: begin
        if (!ctrla_en_ff) nxt_state = fpll_pkg::FPLL_ST_OFF;
        else if (lock_ff) nxt_state = fpll_pkg::FPLL_ST_RUN;
      end
      fpll_pkg::FPLL_ST_RUN: begin
        if (!ctrla_en_ff) nxt_state = fpll_pkg::FPLL_ST_OFF;
      end
    endcase
    unique case (nxt_state)
      fpll_pkg::FPLL_ST_FAST: nxt_gate = 1'b1;
      fpll_pkg::FPLL_ST_RUN:  nxt_gate = ctrlb_ff.lock_bypass || nxt_lock;
      default:                nxt_gate = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ctrla_en_ff <= 1'(`FPLL_CTRLA_RST >> `FPLL_CTRLA_ENABLE);
      en_d_ff     <= 1'b0;
      ctrlb_ff    <= '0;
      ratio_ff    <= '0;
      flag_ff     <= 3'h0;
      inten_ff    <= 3'h0;
      bvalid_ff   <= 1'b0;
      bresp_ff    <= 2'h0;
      rvalid_ff   <= 1'b0;
      rdata_ff    <= 32'h00000000;
      rresp_ff    <= 2'h0;
      state_ff    <= fpll_pkg::FPLL_ST_OFF;
      lock_ff     <= 1'b0;
      settle_ff   <= 4'h0;
      gate_ff     <= 1'b0;
    end else begin
      ctrla_en_ff <= nxt_ctrla_en;
      en_d_ff     <= ctrla_en_ff;
      ctrlb_ff    <= nxt_ctrlb;
      ratio_ff    <= nxt_ratio;
      flag_ff     <= nxt_flag;
      inten_ff    <= nxt_inten;
      bvalid_ff   <= nxt_bvalid;
      bresp_ff    <= nxt_bresp;
      rvalid_ff   <= nxt_rvalid;
      rdata_ff    <= nxt_rdata;
      rresp_ff    <= nxt_rresp;
      state_ff    <= nxt_state;
      lock_ff     <= nxt_lock;
      settle_ff   <= nxt_settle;
      gate_ff     <= nxt_gate;
    end
  end

  // oscillator control and output
  assign dco_ctl.ratio_sixteenths =
    {1'b0, ratio_ff.loop_ratio_integer, 4'h0} + 17'h00010
    + {13'h0000, ratio_ff.loop_ratio_fraction};
  assign dco_ctl.fraction_mode = (ratio_ff.loop_ratio_fraction != 4'h0);
  assign dco_ctl.filter = (ctrlb_ff.filter != 2'h0) ? ctrlb_ff.filter
    : (dco_ctl.fraction_mode ? `FPLL_FILTER_AUTO_FRAC
                             : `FPLL_FILTER_AUTO_INT);
  assign dco_ctl.converter_bypass = ctrlb_ff.converter_bypass_enable;
  assign dco_ctl.osc_reset = (state_ff == fpll_pkg::FPLL_ST_OFF);
  assign final_clock_gate  = gate_ff;
  assign pll_output_clock  = oscillator_raw_clock && gate_ff;
  assign irq = |(flag_ff & inten_ff);
endmodule

/* tb/fpll_checker.sv */
// port assertions of the pll controller
// bound into fpll_ctrl; one clock, sync reset
`timescale 1ns/1ps
module fpll_checker (
  input wire logic                    clk_sys,
  input wire logic                    rstn,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  input wire logic                    oscillator_raw_clock,
  input wire logic                    pll_output_clock,
  input wire logic                    final_clock_gate,
  input wire fpll_pkg::fpll_dco_ctl_t dco_ctl
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_wtake;
    s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  endsequence
  property p_wresp; s_wtake |=> s_axi_bvalid; endproperty
  a_wresp: assert property (p_wresp) else $error("no write response");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  property p_wref; s_axi_bvalid |-> !s_axi_awready; endproperty
  a_wref: assert property (p_wref) else $error("write taken early");
  property p_rresp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rresp: assert property (p_rresp) else $error("no read response");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
  a_rhold: assert property (p_rhold) else $error("rvalid dropped");
  property p_gate;
    pll_output_clock == (oscillator_raw_clock && final_clock_gate);
  endproperty
  a_gate: assert property (p_gate) else $error("output ungated");
  property p_frac;
    dco_ctl.fraction_mode == (dco_ctl.ratio_sixteenths[3:0] != 4'h0);
  endproperty
  a_frac: assert property (p_frac) else $error("mode wrong");
  property p_ratio; dco_ctl.ratio_sixteenths >= 17'h10; endproperty
  a_ratio: assert property (p_ratio) else $error("ratio below one");
  property p_off;
    dco_ctl.osc_reset && $past(dco_ctl.osc_reset) |-> !final_clock_gate;
  endproperty
  a_off: assert property (p_off) else $error("gate open when off");
endmodule

bind fpll_ctrl fpll_checker fpll_checker_inst (.*);

/* tb/fpll_partner.sv */
// reference sources and oscillator core model
// slow clocks derived from clk_sys; lock set by the bench
`timescale 1ns/1ps
module fpll_partner (
  input  wire logic clk_sys,
  input  wire logic lock_req,
  output logic      crystal_32k_oscillator,
  output logic      main_crystal_oscillator,
  output logic      generic_reference_clock,
  output logic      lock_timer_clock,
  output logic      oscillator_raw_clock,
  output logic      osc_startup_done,
  output logic      pll_core_lock
);
  logic [3:0] cnt_ff = 4'h0;
  always_ff @(posedge clk_sys) cnt_ff <= cnt_ff + 4'h1;
  assign crystal_32k_oscillator  = cnt_ff[3];
  assign main_crystal_oscillator = cnt_ff[1];
  assign generic_reference_clock = cnt_ff[2];
  assign lock_timer_clock        = cnt_ff[2];
  assign oscillator_raw_clock    = cnt_ff[0];
  assign osc_startup_done        = 1'b1;
  assign pll_core_lock           = lock_req;
endmodule

/* tb/fpll_ctrl_tb.sv */
// self-checking bench of the pll controller
// assumes fpll_partner drives the source and core inputs
`timescale 1ns/1ps
module fpll_ctrl_tb;
  logic        clk_sys, rstn, lock_req, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs_v;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, pll_core_lock, osc_startup_done;
  logic        crystal_32k_oscillator, main_crystal_oscillator;
  logic        generic_reference_clock, lock_timer_clock;
  logic        oscillator_raw_clock, pll_reference_clock;
  logic        pll_output_clock, final_clock_gate;
  fpll_pkg::fpll_dco_ctl_t dco_ctl;
  int          bad_count = 0;
  int          checks = 0;

  fpll_ctrl fpll_ctrl_inst (.*);
  fpll_partner fpll_partner_inst (.*);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task print_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    checks++;
    if (seen !== ex) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  task tmo(input int n);
    if (n >= 1000) begin
      chk("wait", 32'h0, 32'h1);
      print_verdict;
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    n = 0;
    do begin @(negedge clk_sys); n++; end while (!s_axi_awready && n < 1000);
    tmo(n);
    @(posedge clk_sys);
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    n = 0;
    do begin @(negedge clk_sys); n++; end while (!s_axi_bvalid && n < 1000);
    tmo(n);
    rs_v = s_axi_bresp;
    @(posedge clk_sys);
    s_axi_bready <= 1'b0;
    @(negedge clk_sys);
  endtask

  task rd(input logic [7:0] a);
    int n;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    n = 0;
    do begin @(negedge clk_sys); n++; end while (!s_axi_arready && n < 1000);
    tmo(n);
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b0;
    n = 0;
    do begin @(negedge clk_sys); n++; end while (!s_axi_rvalid && n < 1000);
    tmo(n);
    rd_v = s_axi_rdata;
    rs_v = s_axi_rresp;
    @(posedge clk_sys);
    s_axi_rready <= 1'b0;
    @(negedge clk_sys);
  endtask

  task wt(input logic v);
    int n;
    n = 0;
    do begin @(negedge clk_sys); n++; end
      while (final_clock_gate !== v && n < 1000);
    tmo(n);
  endtask

  task t_reset;
    chk("sixteenths", dco_ctl.ratio_sixteenths, 32'h10);
    chk("osc_reset", dco_ctl.osc_reset, 32'h1);
    rd(8'h0C);
    chk("status", rd_v, 32'h0);
    rd(8'h1C);
    chk("rresp", rs_v, 32'h2);
    wr(8'h1C, 32'hFFFFFFFF);
    chk("bresp", rs_v, 32'h2);
    $display("reset done");
  endtask

  task t_ratio;
    wr(8'h08, 32'h00030002);
    chk("sixteenths", dco_ctl.ratio_sixteenths, 32'h33);
    chk("frac_mode", dco_ctl.fraction_mode, 32'h1);
    chk("filter", dco_ctl.filter, 32'h2);
    wr(8'h04, 32'h00000007);
    chk("filter", dco_ctl.filter, 32'h3);
    chk("conv_bypass", dco_ctl.converter_bypass, 32'h1);
    wr(8'h08, 32'h00000005);
    chk("sixteenths", dco_ctl.ratio_sixteenths, 32'h60);
    chk("frac_mode", dco_ctl.fraction_mode, 32'h0);
    wr(8'h04, 32'h0);
    chk("filter", dco_ctl.filter, 32'h1);
    $display("ratio done");
  endtask

  task t_lock;
    wr(8'h14, 32'h2);
    wr(8'h00, 32'h2);
    chk("osc_reset", dco_ctl.osc_reset, 32'h0);
    @(posedge clk_sys) lock_req <= 1'b1;
    wt(1'b1);
    rd(8'h0C);
    chk("status", rd_v[2:0], 32'h7);
    wr(8'h08, 32'h00000006);
    wt(1'b0);
    rd(8'h0C);
    chk("lock", rd_v[0], 32'h0);
    rd(8'h10);
    chk("lost_flag", rd_v[1], 32'h1);
    chk("irq", irq, 32'h1);
    wt(1'b1);
    wr(8'h10, 32'h2);
    rd(8'h10);
    chk("lost_flag", rd_v[1], 32'h0);
    chk("irq", irq, 32'h0);
    $display("lock done");
  endtask

  task t_bypass;
    wr(8'h04, 32'h00001000);
    wr(8'h08, 32'h00000005);
    repeat (4) @(negedge clk_sys);
    chk("gate", final_clock_gate, 32'h1);
    rd(8'h0C);
    chk("lock", rd_v[0], 32'h0);
    $display("bypass done");
  endtask

  task t_timer;
    logic p;
    int   r;
    r = 0;
    wr(8'h00, 32'h0);
    wt(1'b0);
    @(posedge clk_sys) lock_req <= 1'b0;
    wr(8'h04, 32'h00010010);
    p = pll_reference_clock;
    repeat (64) begin
      @(negedge clk_sys);
      if (pll_reference_clock && !p) r++;
      p = pll_reference_clock;
    end
    chk("ref_rises", r, 32'h4);
    wr(8'h04, 32'h00000120);
    wr(8'h10, 32'h7);
    wr(8'h00, 32'h2);
    wt(1'b1);
    rd(8'h0C);
    chk("lock", rd_v[0], 32'h1);
    rd(8'h10);
    chk("timeout_flag", rd_v[2], 32'h1);
    chk("lock_flag", rd_v[0], 32'h1);
    $display("timer done");
  endtask

  initial begin
    {rstn, lock_req, s_axi_awvalid, s_axi_wvalid} = 4'h0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset;
    t_ratio;
    t_lock;
    t_bypass;
    t_timer;
    print_verdict;
  end
endmodule
